// file: common/ccl_defs.vh
// constants shared by the current limit and loop configuration block
`ifndef CCL_DEFS_VH
`define CCL_DEFS_VH

// strap pin reading as delivered by the pin sensing front end
`define CCL_STRAP_LOW 2'h0
`define CCL_STRAP_OPEN 2'h1
`define CCL_STRAP_HIGH 2'h2
`define CCL_STRAP_RES 2'h3

// sense methods
`define CCL_SENSE_GND 2'h0
`define CCL_SENSE_DOWN 2'h1
`define CCL_SENSE_UP 2'h2

// resistor index: 0 is the lowest standard value, 8 values per method group
`define CCL_GROUP_SHIFT 3
`define CCL_RES_THR_LAST 5'h14
`define CCL_THR_STEP_RES 7'h05
`define CCL_THR_MAX 7'h64
`define CCL_THR_GRID_BASE 7'h14
`define CCL_THR_GRID_A 7'h0a
`define CCL_THR_GRID_B 7'h1e
`define CCL_VIOL_TRI 4'h4

// blanking in ns and clock period in ps
`define CCL_BLANK_GND_NS 672
`define CCL_BLANK_IND_NS 352
`define CCL_CLK_PERIOD_PS 25000

// compensation presets: proportional gain [7:0], integral gain [15:8]
`define CCL_COMP_HIGHQ 16'h0418
`define CCL_COMP_REAL 16'h0c30
`define CCL_COMP_LOWQ 16'h0210

// register byte offsets
`define CCL_REG_CTRL 5'h00
`define CCL_REG_LIMIT 5'h04
`define CCL_REG_COMP 5'h08
`define CCL_REG_VREF 5'h0c
`define CCL_REG_STATUS 5'h10

// reset values
`define CCL_VREF_RST 12'h800
`define CCL_WIN_RST 8'h10
`define CCL_DT_RST 4'h4

// field positions and bus response codes
`define CCL_STAT_FAULT 1
`define CCL_AXI_OKAY 2'h0
`define CCL_AXI_SLVERR 2'h2

`endif

// file: logic/ccl_strap_dec.v
// combinational decode of the current limit and compensation straps
`timescale 1ns/1ps
`include "ccl_defs.vh"
module ccl_strap_dec (
  input wire [1:0] strap_a_mode,
  input wire [4:0] strap_a_ridx,
  input wire [1:0] strap_b_mode,
  input wire [4:0] strap_b_ridx,
  input wire [1:0] comp_mode,
  output reg [6:0] thr_mv,
  output reg [1:0] method,
  output reg [3:0] viol_allowed,
  output reg [15:0] comp_gains
);
  wire [4:0] b_group = strap_b_ridx >> `CCL_GROUP_SHIFT;
  always @* begin
    thr_mv = `CCL_THR_GRID_BASE;
    method = `CCL_SENSE_GND;
    viol_allowed = `CCL_VIOL_TRI;
    if (strap_a_mode == `CCL_STRAP_RES) begin
      // resistor on pin a sets the threshold in fixed steps
      if (strap_a_ridx > `CCL_RES_THR_LAST)
        thr_mv = `CCL_THR_MAX;
      else
        thr_mv = {2'h0, strap_a_ridx} * `CCL_THR_STEP_RES;
      if (strap_b_mode == `CCL_STRAP_RES) begin
        method = b_group[1:0];
        viol_allowed = {strap_b_ridx[2:0], 1'b1};
      end else begin
        method = strap_b_mode;
        viol_allowed = `CCL_VIOL_TRI;
      end
    end else begin
      // no resistor on pin a: ground sensing always
      method = `CCL_SENSE_GND;
      if (strap_b_mode != `CCL_STRAP_RES)
        thr_mv = `CCL_THR_GRID_BASE + {5'h00, strap_a_mode} * `CCL_THR_GRID_A
                 + {5'h00, strap_b_mode} * `CCL_THR_GRID_B;
      else
        thr_mv = `CCL_THR_GRID_BASE + {5'h00, strap_a_mode} * `CCL_THR_GRID_A;
    end
  end

  // the spare compensation strap has no input here at all
  always @* begin
    case (comp_mode)
      `CCL_STRAP_HIGH: comp_gains = `CCL_COMP_HIGHQ;
      `CCL_STRAP_LOW: comp_gains = `CCL_COMP_LOWQ;
      default: comp_gains = `CCL_COMP_REAL;
    endcase
  end
endmodule

// file: logic/ccl_top.v
// current limit configuration, control loop, pwm and dead-time trim
`timescale 1ns/1ps
`include "ccl_defs.vh"
module ccl_top #(
  parameter PERIOD = 100,
  parameter DT_MIN = 1,
  parameter DT_MAX = 15,
  parameter GAIN_SHIFT = 6
) (
  input wire CORE_CLK,
  input wire RST_B,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [4:0] S_AXI_AWADDR,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  output reg [1:0] S_AXI_BRESP,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  input wire [4:0] S_AXI_ARADDR,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  input wire [1:0] LIMIT_STRAP_A_MODE,
  input wire [4:0] LIMIT_STRAP_A_RIDX,
  input wire [1:0] LIMIT_STRAP_B_MODE,
  input wire [4:0] LIMIT_STRAP_B_RIDX,
  input wire [1:0] COMP_STRAP_MODE,
  input wire [11:0] VOUT_SAMPLE,
  input wire ISENSE_OVER,
  output reg UPPER_SWITCH_DRV,
  output reg LOWER_SWITCH_DRV,
  output reg [6:0] LIMIT_THRESHOLD_MV,
  output reg [1:0] SENSE_METHOD,
  output reg OC_FAULT,
  output reg REGULATING
);
  localparam BLANK_GND = (`CCL_BLANK_GND_NS * 1000 + `CCL_CLK_PERIOD_PS - 1) / `CCL_CLK_PERIOD_PS;
  localparam BLANK_IND = (`CCL_BLANK_IND_NS * 1000 + `CCL_CLK_PERIOD_PS - 1) / `CCL_CLK_PERIOD_PS;
  localparam [7:0] PER = PERIOD[7:0];
  localparam [7:0] PER_LAST = PER - 8'h01;
  localparam [3:0] DTMN = DT_MIN[3:0], DTMX = DT_MAX[3:0];
  localparam [5:0] BLK_GND = BLANK_GND[5:0], BLK_IND = BLANK_IND[5:0];
  localparam [27:0] INT_MAX = 28'h07fffff, INT_MIN = 28'hf800000;
  localparam ST_WAIT = 2'h0, ST_LATCH = 2'h1, ST_RUN = 2'h2;
  wire [6:0] dec_thr;
  wire [1:0] dec_method;
  wire [3:0] dec_viol;
  wire [15:0] dec_comp;
  ccl_strap_dec u_dec (
    .strap_a_mode(LIMIT_STRAP_A_MODE),
    .strap_a_ridx(LIMIT_STRAP_A_RIDX),
    .strap_b_mode(LIMIT_STRAP_B_MODE),
    .strap_b_ridx(LIMIT_STRAP_B_RIDX),
    .comp_mode(COMP_STRAP_MODE),
    .thr_mv(dec_thr),
    .method(dec_method),
    .viol_allowed(dec_viol),
    .comp_gains(dec_comp)
  );
  reg [1:0] st_q, fast_q;
  reg run_q, fault_q, aw_held_q, w_held_q, dt_up_q, cyc_viol_q, sense_prev_q;
  reg [3:0] viol_q, wstrb_q, dt_q, vcnt_q;
  reg [15:0] comp_q;
  reg [11:0] vref_q;
  reg [7:0] win_q, cnt_q, duty_q, duty_prev_q;
  reg [4:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [27:0] integ_q;
  reg [5:0] blank_q;
  // a held write lands only once the previous response has been accepted
  wire do_wr = aw_held_q & w_held_q & ~S_AXI_BVALID;
  wire wr_status = do_wr & (awaddr_q[4:2] == `CCL_REG_STATUS >> 2);
  assign S_AXI_AWREADY = ~aw_held_q;
  assign S_AXI_WREADY = ~w_held_q;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  wire period_end = (cnt_q == PER_LAST);
  // strap latch sequence: one settle cycle, then capture
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= ST_WAIT;
    end else begin
      case (st_q)
        ST_WAIT: st_q <= ST_LATCH;
        ST_LATCH: st_q <= ST_RUN;
        ST_RUN: st_q <= ST_RUN;
        default: st_q <= ST_WAIT;
      endcase
    end
  end
  // registers; bus writes replace the latched strap values
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_q <= 1'b0;
      LIMIT_THRESHOLD_MV <= `CCL_THR_GRID_BASE;
      SENSE_METHOD <= `CCL_SENSE_GND;
      viol_q <= `CCL_VIOL_TRI;
      comp_q <= `CCL_COMP_REAL;
      vref_q <= `CCL_VREF_RST;
      win_q <= `CCL_WIN_RST;
      fault_q <= 1'b0;
    end else begin
      if (st_q == ST_LATCH) begin
        LIMIT_THRESHOLD_MV <= dec_thr;
        SENSE_METHOD <= dec_method;
        viol_q <= dec_viol;
        comp_q <= dec_comp;
      end
      if (do_wr) begin
        case (awaddr_q[4:2])
          `CCL_REG_CTRL >> 2:
            if (wstrb_q[0]) run_q <= wdata_q[0];
          `CCL_REG_LIMIT >> 2: begin
            if (wstrb_q[0]) LIMIT_THRESHOLD_MV <= wdata_q[6:0];
            if (wstrb_q[1] && wdata_q[9:8] != 2'h3) SENSE_METHOD <= wdata_q[9:8];
            if (wstrb_q[1]) viol_q <= wdata_q[15:12];
          end
          `CCL_REG_COMP >> 2: begin
            if (wstrb_q[0]) comp_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) comp_q[15:8] <= wdata_q[15:8];
          end
          `CCL_REG_VREF >> 2: begin
            if (wstrb_q[0]) vref_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) vref_q[11:8] <= wdata_q[11:8];
            if (wstrb_q[2]) win_q <= wdata_q[23:16];
          end
          default: ;
        endcase
      end
      // a fault in the same cycle as its clear stays set
      if (OC_FAULT)
        fault_q <= 1'b1;
      else if (wr_status && wstrb_q[0] && wdata_q[`CCL_STAT_FAULT])
        fault_q <= 1'b0;
    end
  end
  // write channel: address and data taken in either order
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `CCL_AXI_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (awaddr_q > `CCL_REG_STATUS) ? `CCL_AXI_SLVERR : `CCL_AXI_OKAY;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end
  // read channel, answer one cycle after the address is taken
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `CCL_AXI_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= `CCL_AXI_OKAY;
      case (S_AXI_ARADDR[4:2])
        `CCL_REG_CTRL >> 2: S_AXI_RDATA <= {31'h0, run_q};
        `CCL_REG_LIMIT >> 2:
          S_AXI_RDATA <= {16'h0, viol_q, 2'h0, SENSE_METHOD, 1'b0, LIMIT_THRESHOLD_MV};
        `CCL_REG_COMP >> 2: S_AXI_RDATA <= {16'h0, comp_q};
        `CCL_REG_VREF >> 2: S_AXI_RDATA <= {8'h0, win_q, 4'h0, vref_q};
        `CCL_REG_STATUS >> 2:
          S_AXI_RDATA <= {4'h0, vcnt_q, 4'h0, dt_q, duty_q, 4'h0, fast_q,
                          fault_q, st_q == ST_RUN};
        default: begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= `CCL_AXI_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
  // error, integration and duty conversion once per period
  wire signed [12:0] err = $signed({1'b0, vref_q}) - $signed({1'b0, VOUT_SAMPLE});
  wire signed [27:0] ki_term = err * $signed({1'b0, comp_q[15:8]});
  wire signed [27:0] kp_term = err * $signed({1'b0, comp_q[7:0]});
  wire signed [27:0] integ_sum = $signed(integ_q) + ki_term;
  wire signed [27:0] integ_sat = (integ_sum > $signed(INT_MAX)) ? $signed(INT_MAX) :
                                 (integ_sum < $signed(INT_MIN)) ? $signed(INT_MIN) :
                                 integ_sum;
  wire signed [27:0] ctl = (integ_sat + kp_term) >>> GAIN_SHIFT;
  wire [7:0] duty_d = (ctl < 0) ? 8'h00 : (ctl > $signed({20'h0, PER})) ? PER : ctl[7:0];
  wire active = run_q & (st_q == ST_RUN);
  // outside the window the fast path takes the switches
  wire under = ({1'b0, VOUT_SAMPLE} + {5'h0, win_q}) < {1'b0, vref_q};
  wire over = {1'b0, VOUT_SAMPLE} > ({1'b0, vref_q} + {5'h0, win_q});

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_q <= 8'h00;
      duty_q <= 8'h00;
      duty_prev_q <= 8'h00;
      integ_q <= 28'h0000000;
      dt_q <= `CCL_DT_RST;
      dt_up_q <= 1'b0;
      fast_q <= 2'h0;
      REGULATING <= 1'b0;
    end else begin
      REGULATING <= active;
      cnt_q <= period_end ? 8'h00 : cnt_q + 8'h01;
      if (!active) begin
        integ_q <= 28'h0000000;
        duty_q <= 8'h00;
        fast_q <= 2'h0;
      end else if (period_end) begin
        fast_q <= {over, under};
        if (!under && !over) begin
          integ_q <= integ_sat;
          duty_q <= duty_d;
          // trim purely from the duty trend, no gate or switch sensing
          duty_prev_q <= duty_q;
          if (duty_q > duty_prev_q) begin
            dt_up_q <= ~dt_up_q;
            if (!dt_up_q && dt_q < DTMX) dt_q <= dt_q + 4'h1;
            if (dt_up_q && dt_q > DTMN) dt_q <= dt_q - 4'h1;
          end else begin
            if (dt_up_q && dt_q < DTMX) dt_q <= dt_q + 4'h1;
            if (!dt_up_q && dt_q > DTMN) dt_q <= dt_q - 4'h1;
          end
        end
      end
    end
  end
  // gate windows with dead time at both ends of each phase
  wire [7:0] dt8 = {4'h0, dt_q};
  wire [7:0] tail = PER - dt8;
  wire top_lin = (cnt_q >= dt8) && (cnt_q < duty_q);
  wire bot_lin = (cnt_q >= duty_q + dt8) && (cnt_q < tail);
  wire full_on = (cnt_q >= dt8) && (cnt_q < tail);
  reg top_d;
  reg bot_d;
  always @* begin
    top_d = 1'b0;
    bot_d = 1'b0;
    if (active) begin
      case (fast_q)
        2'h1: top_d = full_on;
        2'h2: bot_d = full_on;
        default: begin
          top_d = top_lin;
          bot_d = bot_lin;
        end
      endcase
    end
  end
  // blanking and violation counting on the sensed phase
  wire sense_on = (SENSE_METHOD == `CCL_SENSE_UP) ? top_d : bot_d;
  wire [5:0] blank_len = (SENSE_METHOD == `CCL_SENSE_GND) ? BLK_GND : BLK_IND;
  wire [3:0] vcnt_inc = vcnt_q + 4'h1;

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      UPPER_SWITCH_DRV <= 1'b0;
      LOWER_SWITCH_DRV <= 1'b0;
      sense_prev_q <= 1'b0;
      blank_q <= 6'h00;
      cyc_viol_q <= 1'b0;
      vcnt_q <= 4'h0;
      OC_FAULT <= 1'b0;
    end else begin
      UPPER_SWITCH_DRV <= top_d & ~bot_d;
      LOWER_SWITCH_DRV <= bot_d & ~top_d;
      sense_prev_q <= sense_on;
      OC_FAULT <= 1'b0;
      if (sense_on && !sense_prev_q)
        blank_q <= 6'h00;
      else if (sense_on && blank_q < blank_len)
        blank_q <= blank_q + 6'h01;
      if (sense_on && sense_prev_q && blank_q >= blank_len && ISENSE_OVER)
        cyc_viol_q <= 1'b1;
      if (period_end) begin
        cyc_viol_q <= 1'b0;
        if (active && cyc_viol_q) begin
          // full budget tolerated; comparing the count itself avoids a wrap at 15
          if (vcnt_q >= viol_q) begin
            OC_FAULT <= 1'b1;
            vcnt_q <= 4'h0;
          end else begin
            vcnt_q <= vcnt_inc;
          end
        end else begin
          vcnt_q <= 4'h0;
        end
      end
    end
  end
endmodule

// file: bench/ccl_props.sv
// concurrent checks on the ports of the current limit and loop block
`timescale 1ns/1ps
module ccl_props (
  input wire CORE_CLK,
  input wire RST_B,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire UPPER_SWITCH_DRV,
  input wire LOWER_SWITCH_DRV,
  input wire OC_FAULT,
  input wire REGULATING
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  a_no_overlap: assert property (!(UPPER_SWITCH_DRV && LOWER_SWITCH_DRV))
    else $error("both gate drives high");
  a_gap_after_upper: assert property ($fell(UPPER_SWITCH_DRV) |-> !LOWER_SWITCH_DRV)
    else $error("lower drive on with no gap after upper");
  a_gap_after_lower: assert property ($fell(LOWER_SWITCH_DRV) |-> !UPPER_SWITCH_DRV)
    else $error("upper drive on with no gap after lower");
  a_fault_pulse: assert property (OC_FAULT |=> !OC_FAULT)
    else $error("fault event longer than one cycle");
  a_idle_drives: assert property (!REGULATING [*2] |-> !UPPER_SWITCH_DRV && !LOWER_SWITCH_DRV)
    else $error("gate drive active while not regulating");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
    S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write response late");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while data pending");
endmodule

bind ccl_top ccl_props ccl_props_i (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .UPPER_SWITCH_DRV(UPPER_SWITCH_DRV),
  .LOWER_SWITCH_DRV(LOWER_SWITCH_DRV), .OC_FAULT(OC_FAULT), .REGULATING(REGULATING));

// file: bench/ccl_stage_model.sv
// behavioural power stage: output voltage level and current sense comparator
`timescale 1ns/1ps
module ccl_stage_model (
  input wire clk,
  input wire rst_b,
  input wire lower_on,
  input wire [1:0] vmode,
  input wire [6:0] over_len,
  output logic [11:0] vout,
  output logic isense_over
);
  logic [6:0] on_cnt_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) on_cnt_q <= 7'h00;
    else if (!lower_on) on_cnt_q <= 7'h00;
    else if (on_cnt_q != 7'h7f) on_cnt_q <= on_cnt_q + 7'h01;
  end
  // trips for the first over_len cycles of the lower phase, like ringing after a switch edge
  assign isense_over = lower_on && (on_cnt_q < over_len);
  always_comb begin
    case (vmode)
      2'h1: vout = 12'h600;
      2'h2: vout = 12'ha00;
      2'h3: vout = 12'h7f2;
      default: vout = 12'h800;
    endcase
  end
endmodule

// file: bench/tb_top.sv
// self-checking testbench for the current limit and loop configuration block
`timescale 1ns/1ps
`include "ccl_defs.vh"
module tb_top;
  logic clk = 0, rst_b = 0, isense_over;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, upper, lower, oc_fault, regulating;
  logic [4:0] awaddr = 0, araddr = 0, a_ridx = 0, b_ridx = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [1:0] bresp, rresp, rs, a_mode = 0, b_mode = 0, c_mode = 0, sense, vmode = 0;
  logic [11:0] vout;
  logic [6:0] thr, over_len = 0;
  int error_cnt = 0, checks_done = 0, cycles = 0;
  always #12.5 clk = ~clk;

  ccl_top ccl_top_i (.CORE_CLK(clk), .RST_B(rst_b), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .LIMIT_STRAP_A_MODE(a_mode), .LIMIT_STRAP_A_RIDX(a_ridx), .LIMIT_STRAP_B_MODE(b_mode),
    .LIMIT_STRAP_B_RIDX(b_ridx), .COMP_STRAP_MODE(c_mode), .VOUT_SAMPLE(vout),
    .ISENSE_OVER(isense_over), .UPPER_SWITCH_DRV(upper), .LOWER_SWITCH_DRV(lower),
    .LIMIT_THRESHOLD_MV(thr), .SENSE_METHOD(sense), .OC_FAULT(oc_fault),
    .REGULATING(regulating));
  ccl_stage_model ccl_stage_model_i (.clk(clk), .rst_b(rst_b), .lower_on(lower),
    .vmode(vmode), .over_len(over_len), .vout(vout), .isense_over(isense_over));

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a hung handshake must still end in the verdict
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
    do @(negedge clk); while (!(awready && wready));
    @(posedge clk);
    awvalid <= 0; wvalid <= 0;
    do @(negedge clk); while (!bvalid);
    @(posedge clk);
    bready <= 1;
    @(negedge clk);
    r = bresp;
    @(posedge clk);
    bready <= 0;
  endtask
  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 0;
    do @(negedge clk); while (!rvalid);
    @(posedge clk);
    rready <= 1;
    @(negedge clk);
    d = rdata; r = rresp;
    @(posedge clk);
    rready <= 0;
  endtask
  // straps only count at the latch after reset, so each setting needs its own reset
  task automatic strap_reset(input logic [1:0] am, input logic [4:0] ai, input logic [1:0] bm,
      input logic [4:0] bi, input logic [1:0] cm);
    @(posedge clk);
    rst_b <= 0; a_mode <= am; a_ridx <= ai; b_mode <= bm; b_ridx <= bi; c_mode <= cm;
    repeat (5) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic expect_cfg(input logic [6:0] t, input logic [1:0] m, input logic [3:0] v);
    axi_read(`CCL_REG_LIMIT, rd, rs);
    check("threshold", thr, t);
    check("method", sense, m);
    check("violations", rd[15:12], v);
  endtask

  task automatic t_straps();
    for (int i = 0; i < 24; i++) begin
      strap_reset(`CCL_STRAP_RES, 5'h04, `CCL_STRAP_RES, i[4:0], `CCL_STRAP_OPEN);
      expect_cfg(7'h14, i[4:3], 2 * (i % 8) + 1);
    end
    for (int a = 0; a < 3; a++)
      for (int b = 0; b < 3; b++) begin
        strap_reset(a[1:0], 5'h00, b[1:0], 5'h00, `CCL_STRAP_OPEN);
        expect_cfg(20 + 10 * a + 30 * b, `CCL_SENSE_GND, 4);
      end
    for (int i = 0; i < 21; i++) begin
      strap_reset(`CCL_STRAP_RES, i[4:0], `CCL_STRAP_LOW, 5'h00, `CCL_STRAP_OPEN);
      expect_cfg(5 * i, `CCL_SENSE_GND, 4);
    end
    for (int m = 0; m < 3; m++) begin
      strap_reset(`CCL_STRAP_RES, 5'h0a, m[1:0], 5'h00, `CCL_STRAP_OPEN);
      expect_cfg(7'h32, m[1:0], 4);
    end
  endtask
  task automatic t_comp_bus();
    logic [15:0] preset[3];
    preset[0] = `CCL_COMP_LOWQ; preset[1] = `CCL_COMP_REAL; preset[2] = `CCL_COMP_HIGHQ;
    for (int m = 0; m < 3; m++) begin
      strap_reset(`CCL_STRAP_LOW, 5'h00, `CCL_STRAP_LOW, 5'h00, m[1:0]);
      axi_read(`CCL_REG_COMP, rd, rs);
      check("comp preset", rd[15:0], preset[m]);
    end
    a_mode <= `CCL_STRAP_HIGH; c_mode <= `CCL_STRAP_LOW;
    axi_read(`CCL_REG_COMP, rd, rs);
    check("comp after strap change", rd[15:0], `CCL_COMP_HIGHQ);
    check("threshold after strap change", thr, 7'h14);
    axi_write(`CCL_REG_COMP, 32'h0000_1234, rs);
    axi_read(`CCL_REG_COMP, rd, rs);
    check("comp written", rd[15:0], 16'h1234);
    axi_write(`CCL_REG_LIMIT, 32'h0000_212d, rs);
    @(negedge clk);
    check("threshold written", thr, 7'h2d);
    check("method written", sense, `CCL_SENSE_DOWN);
    axi_read(5'h14, rd, rs);
    check("unmapped read resp", rs, `CCL_AXI_SLVERR);
    check("unmapped read data", rd, 0);
    axi_write(5'h18, 32'hffff_ffff, rs);
    check("unmapped write resp", rs, `CCL_AXI_SLVERR);
  endtask
  task automatic t_fast();
    int up, lo;
    strap_reset(`CCL_STRAP_LOW, 5'h00, `CCL_STRAP_LOW, 5'h00, `CCL_STRAP_OPEN);
    axi_write(`CCL_REG_CTRL, 32'h1, rs);
    for (int m = 1; m <= 2; m++) begin
      vmode <= m[1:0];
      repeat (300) @(posedge clk);
      up = 0;
      lo = 0;
      repeat (100) begin
        @(negedge clk);
        up += upper;
        lo += lower;
      end
      check("regulating", regulating, 1);
      check("upper share", up >= 70, m == 1);
      check("lower share", lo >= 70, m == 2);
      axi_read(`CCL_REG_STATUS, rd, rs);
      check("fast mode", rd[3:2], m);
    end
    vmode <= 0;
  endtask
  task automatic t_blank();
    logic seen;
    for (int k = 0; k < 3; k++) begin
      strap_reset(`CCL_STRAP_RES, 5'h04, `CCL_STRAP_RES, k == 1 ? 5'h08 : 5'h00, 2'h1);
      axi_write(`CCL_REG_CTRL, 32'h1, rs);
      vmode <= 2'h2;
      over_len <= k == 2 ? 7'h7f : 7'h14;
      seen = 0;
      repeat (600) begin
        @(negedge clk);
        seen |= oc_fault;
      end
      check("fault event", seen, k != 0);
      axi_read(`CCL_REG_STATUS, rd, rs);
      check("fault sticky", rd[1], k != 0);
    end
    over_len <= 0;
    vmode <= 0;
  endtask
  task automatic t_loop();
    logic [7:0] d1;
    strap_reset(`CCL_STRAP_LOW, 5'h00, `CCL_STRAP_LOW, 5'h00, `CCL_STRAP_OPEN);
    axi_write(`CCL_REG_CTRL, 32'h1, rs);
    vmode <= 2'h3;
    repeat (300) @(posedge clk);
    axi_read(`CCL_REG_STATUS, rd, rs);
    d1 = rd[15:8];
    repeat (2000) @(posedge clk);
    axi_read(`CCL_REG_STATUS, rd, rs);
    check("duty rises below reference", rd[15:8] > d1, 1);
    check("dead time in range", rd[19:16] >= 1 && rd[19:16] <= 15, 1);
  endtask

  initial begin
    t_straps();
    t_comp_bus();
    t_fast();
    t_blank();
    t_loop();
    print_verdict();
  end
endmodule
